// ==== hw/scsi_parity_pkg.sv ====
// Purpose: constants for the scsi parity control block
// Assumes: plain register port, 32-bit words, byte offsets
// Notes:   bit positions follow the control and status layouts
package scsi_parity_pkg;
   localparam int          ADDR_W            = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL_ZERO     = 8'h00;
   localparam logic [7:0]  OFS_CTRL_ONE      = 8'h04;
   localparam logic [7:0]  OFS_IRQ_EN_ZERO   = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STAT_ZERO = 8'h0C;
   localparam logic [7:0]  OFS_STATUS_ZERO   = 8'h10;
   localparam logic [7:0]  OFS_STATUS_ONE    = 8'h14;
   localparam logic [7:0]  OFS_STATUS_TWO    = 8'h18;
   localparam logic [7:0]  OFS_TEST_FOUR     = 8'h1C;
   localparam logic [7:0]  OFS_DMA_STATUS    = 8'h20;
   localparam logic [7:0]  OFS_DMA_IRQ_EN    = 8'h24;
   localparam logic [7:0]  OFS_IRQ_CLEAR     = 8'h28;
   localparam logic [7:0]  OFS_BAD_PARITY    = 8'h2C;
   // field positions
   localparam int          BIT_ATN_ON_ERR    = 1;
   localparam int          BIT_CHECK_EN      = 3;
   localparam int          BIT_EVEN_SEL      = 2;
   localparam int          BIT_HALT_DIS      = 5;
   localparam int          BIT_PAR_ERR       = 0;
   localparam int          BIT_LIVE_PAR      = 0;
   localparam int          BIT_LATCH_PAR     = 3;
   localparam int          BIT_MASTER_PAR_EN = 3;
   localparam int          BIT_MASTER_DPE    = 6;
   localparam int          BIT_BAD_LOW       = 0;
   localparam int          BIT_BAD_HIGH      = 1;
   // clear-register layout: bit 0 scsi parity error, bit 6 master data parity error
   localparam logic [7:0]  RST_BYTE          = 8'h00;
endpackage

// ==== hw/scsi_parity_control.sv ====
// Purpose: scsi byte-lane parity generation and checking, pci master parity status
// Assumes: all inputs synchronous to i_clk; host decodes its own irq pin choice
// Notes:   one always_ff per concern; registers are 8-bit in a 32-bit word
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Function
// R1 - initiator asserts attention on detected parity error
// R2 - check odd parity only when enabled
// R3 - always generate parity, sense selectable
// R4 - software can force bad outgoing parity
// R5 - parity error sets sticky status bit
// R6 - interrupt only when parity interrupt enabled
// R7 - halt immediately unless halt disabled; an initiator halts at once even with halt disabled
// R8 - target with halt disabled stops at end
// R9 - live lane parity levels readable
// R10 - latched lane parity bits readable
// R11 - master parity check only when enabled
// R12 - target-signalled parity error sets master status
// R13 - master error interrupt gated by enable
// R14 - parity handled per byte lane
module scsi_parity_control
   import scsi_parity_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   input  wire logic              i_initiator,
   input  wire logic              i_wide,
   input  wire logic [15:0]       i_tx_data,
   input  wire logic              i_tx_valid,
   output logic                   o_low_lane_parity,
   output logic                   o_high_lane_parity,
   input  wire logic [15:0]       i_rx_data,
   input  wire logic              i_rx_valid,
   input  wire logic              i_low_lane_parity,
   input  wire logic              i_high_lane_parity,
   input  wire logic              i_xfer_end,
   input  wire logic              i_pci_master_data,
   input  wire logic              i_pci_target_perr,
   output logic                   o_attention_out_n,
   output logic                   o_halt,
   output logic                   o_host_irq_n
);

   logic [7:0]  ctrl_zero_reg;
   logic [7:0]  ctrl_one_reg;
   logic [7:0]  irq_en_zero_reg;
   logic [7:0]  test_four_reg;
   logic [7:0]  dma_irq_en_reg;
   logic        scsi_err_reg;
   logic        master_err_reg;
   logic [1:0]  bad_par_reg;
   logic [15:0] latch_data_reg;
   logic        halt_pending_reg;
   logic        halt_reg;
   logic        atn_reg;
   logic        tx_low_reg;
   logic        tx_high_reg;
   logic [31:0] rdata_reg;

   logic        low_bad;
   logic        high_bad;
   logic        scsi_err_evt;
   logic        master_err_evt;
   logic        clr_wr;
   logic        even_sel;
   logic        scsi_irq;
   logic        master_irq;
   logic [1:0]  latch_par;

   assign even_sel = ctrl_one_reg[BIT_EVEN_SEL];
   assign clr_wr   = i_wr && (i_addr == OFS_IRQ_CLEAR);

   // per-lane odd parity check of a received word
   assign low_bad  = ~(^{i_rx_data[7:0], i_low_lane_parity});                      // [R2] [R14]
   assign high_bad = i_wide && ~(^{i_rx_data[15:8], i_high_lane_parity});           // [R14]
   assign scsi_err_evt = i_rx_valid && ctrl_zero_reg[BIT_CHECK_EN] && (low_bad || high_bad); // [R2]

   // master data phase error seen only when checking enabled
   assign master_err_evt = i_pci_master_data && i_pci_target_perr && test_four_reg[BIT_MASTER_PAR_EN]; // [R11]

   // control registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_zero_reg   <= RST_BYTE;
         ctrl_one_reg    <= RST_BYTE;
         irq_en_zero_reg <= RST_BYTE;
         test_four_reg   <= RST_BYTE;
         dma_irq_en_reg  <= RST_BYTE;
      end else if (i_wr) begin
         unique case (i_addr)
            OFS_CTRL_ZERO:   ctrl_zero_reg   <= i_wdata[7:0];
            OFS_CTRL_ONE:    ctrl_one_reg    <= i_wdata[7:0];
            OFS_IRQ_EN_ZERO: irq_en_zero_reg <= i_wdata[7:0];
            OFS_TEST_FOUR:   test_four_reg   <= i_wdata[7:0];
            OFS_DMA_IRQ_EN:  dma_irq_en_reg  <= i_wdata[7:0];
            default: ;
         endcase
      end
   end

   // one-shot bad parity request, consumed by the next sent word
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bad_par_reg <= 2'h0;
      end else if (i_wr && (i_addr == OFS_BAD_PARITY)) begin
         bad_par_reg <= {i_wdata[BIT_BAD_HIGH], i_wdata[BIT_BAD_LOW]}; // [R4]
      end else if (i_tx_valid) begin
         bad_par_reg <= 2'h0;
      end
   end

   // outgoing parity per lane, even or odd sense, optional inversion
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_low_reg  <= 1'b1;
         tx_high_reg <= 1'b1;
      end else if (i_tx_valid) begin
         tx_low_reg  <= (~(^i_tx_data[7:0]) ^ even_sel) ^ bad_par_reg[0];  // [R3] [R4] [R14]
         tx_high_reg <= (~(^i_tx_data[15:8]) ^ even_sel) ^ bad_par_reg[1]; // [R3] [R4] [R14]
      end
   end
   assign o_low_lane_parity  = tx_low_reg;
   assign o_high_lane_parity = tx_high_reg;

   // sticky status, set wins over clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scsi_err_reg   <= 1'b0;
         master_err_reg <= 1'b0;
      end else begin
         scsi_err_reg   <= scsi_err_evt || (scsi_err_reg && !(clr_wr && i_wdata[BIT_PAR_ERR]));      // [R5]
         master_err_reg <= master_err_evt || (master_err_reg && !(clr_wr && i_wdata[BIT_MASTER_DPE])); // [R12]
      end
   end

   // input latch; its odd parity per lane is derived from the held bytes
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_data_reg <= 16'h0000;
      end else if (i_rx_valid) begin
         latch_data_reg <= i_rx_data;
      end
   end
   assign latch_par = {~(^latch_data_reg[15:8]), ~(^latch_data_reg[7:0])}; // [R10] [R14]

   // attention as initiator on parity error, held until bus released
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         atn_reg <= 1'b0;
      end else if (scsi_err_evt && i_initiator && ctrl_zero_reg[BIT_ATN_ON_ERR]) begin
         atn_reg <= 1'b1; // [R1]
      end else if (!i_initiator) begin
         atn_reg <= 1'b0;
      end
   end
   assign o_attention_out_n = ~atn_reg;

   // halt: immediate, or deferred to transfer end in target mode
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         halt_reg         <= 1'b0;
         halt_pending_reg <= 1'b0;
      end else begin
         if (scsi_err_evt && (i_initiator || !ctrl_one_reg[BIT_HALT_DIS])) begin
            halt_reg <= 1'b1; // [R7]
         end else if (halt_pending_reg && i_xfer_end) begin
            halt_reg <= 1'b1; // [R8]
         end else if (clr_wr && i_wdata[BIT_PAR_ERR]) begin
            halt_reg <= 1'b0;
         end
         if (scsi_err_evt && !i_initiator && ctrl_one_reg[BIT_HALT_DIS]) begin
            halt_pending_reg <= 1'b1; // [R8]
         end else if (i_xfer_end) begin
            halt_pending_reg <= 1'b0;
         end
      end
   end
   assign o_halt = halt_reg;

   // interrupt gating
   assign scsi_irq     = scsi_err_reg && irq_en_zero_reg[BIT_PAR_ERR];     // [R6]
   assign master_irq   = master_err_reg && dma_irq_en_reg[BIT_MASTER_DPE]; // [R13]
   assign o_host_irq_n = ~(scsi_irq || master_irq);

   // read data, one cycle after the strobe only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            OFS_CTRL_ZERO:     rdata_reg <= {24'h000000, ctrl_zero_reg};
            OFS_CTRL_ONE:      rdata_reg <= {24'h000000, ctrl_one_reg};
            OFS_IRQ_EN_ZERO:   rdata_reg <= {24'h000000, irq_en_zero_reg};
            OFS_IRQ_STAT_ZERO: rdata_reg <= {31'h0, scsi_err_reg};
            OFS_STATUS_ZERO:   rdata_reg <= {31'h0, i_low_lane_parity};               // [R9]
            OFS_STATUS_ONE:    rdata_reg <= {28'h0, latch_par[0], 3'h0};              // [R10]
            OFS_STATUS_TWO:    rdata_reg <= {28'h0, latch_par[1], 2'h0, i_high_lane_parity}; // [R9] [R10]
            OFS_TEST_FOUR:     rdata_reg <= {24'h000000, test_four_reg};
            OFS_DMA_STATUS:    rdata_reg <= {25'h0, master_err_reg, 6'h00};
            OFS_DMA_IRQ_EN:    rdata_reg <= {24'h000000, dma_irq_en_reg};
            default:           rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   assign o_rdata = rdata_reg;

   a_atn_on_err: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
      (scsi_err_evt && i_initiator && ctrl_zero_reg[BIT_ATN_ON_ERR]) |=> !o_attention_out_n)
      else $error("attention not raised on parity error");
   a_check_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
      (!ctrl_zero_reg[BIT_CHECK_EN] && !scsi_err_reg) |=> !scsi_err_reg)
      else $error("error flagged with checking off");
   a_tx_sense: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3]
      (i_tx_valid && bad_par_reg == 2'h0) |=> ((^{$past(i_tx_data[7:0]), o_low_lane_parity}) == !$past(even_sel)))
      else $error("wrong outgoing parity sense");
   a_bad_par: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
      (i_tx_valid && bad_par_reg[0]) |=> ((^{$past(i_tx_data[7:0]), o_low_lane_parity}) == $past(even_sel)))
      else $error("forced bad parity not sent");
   a_err_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
      scsi_err_evt |=> scsi_err_reg)
      else $error("parity error status not set");
   a_irq_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6]
      (scsi_err_reg && !irq_en_zero_reg[BIT_PAR_ERR] && !master_irq) |-> o_host_irq_n)
      else $error("interrupt while parity irq disabled");
   a_halt_now: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R7]
      (scsi_err_evt && !ctrl_one_reg[BIT_HALT_DIS]) |=> o_halt)
      else $error("no immediate halt");
   a_halt_late: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
      (halt_pending_reg && i_xfer_end) |=> o_halt)
      else $error("no halt at transfer end");
   a_master_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R12]
      (i_pci_master_data && i_pci_target_perr && test_four_reg[BIT_MASTER_PAR_EN]) |=> master_err_reg)
      else $error("master parity error not recorded");
   a_master_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R13]
      (!dma_irq_en_reg[BIT_MASTER_DPE] && !scsi_irq) |-> o_host_irq_n)
      else $error("master irq asserted while disabled");

   // read port: data stands one cycle after the strobe, zero otherwise
   a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R9]
      (!i_rd) |=> (o_rdata == 32'h0000_0000))
      else $error("read data not zero outside a read");
   a_live_low: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R9]
      (i_rd && i_addr == OFS_STATUS_ZERO) |=> (o_rdata == {31'h0, $past(i_low_lane_parity)}))
      else $error("live low lane parity misread");
   a_live_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R9]
      (i_rd && i_addr == OFS_STATUS_TWO) |=> (o_rdata[BIT_LIVE_PAR] == $past(i_high_lane_parity)))
      else $error("live high lane parity misread");
   a_latch_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
      (i_rd && i_addr == OFS_STATUS_ONE) |=> (o_rdata == {28'h0, $past(latch_par[0]), 3'h0}))
      else $error("latched low parity misread");
   a_stat_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
      (i_rd && i_addr == OFS_IRQ_STAT_ZERO) |=> (o_rdata == {31'h0, $past(scsi_err_reg)}))
      else $error("parity error status misread");
   a_dma_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R12]
      (i_rd && i_addr == OFS_DMA_STATUS) |=> (o_rdata[BIT_MASTER_DPE] == $past(master_err_reg)))
      else $error("master parity status misread");

   // input latch follows received words only
   a_latch_low: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
      i_rx_valid |=> (latch_par[0] == ~(^$past(i_rx_data[7:0]))))
      else $error("latched low parity wrong");
   a_latch_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
      i_rx_valid |=> (latch_par[1] == ~(^$past(i_rx_data[15:8]))))
      else $error("latched high parity wrong");
   a_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
      !i_rx_valid |=> $stable(latch_data_reg))
      else $error("input latch changed without a word");

   // receive check is odd per lane, whatever the transmit sense
   a_check_odd: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2] [R14]
      (i_rx_valid && ctrl_zero_reg[BIT_CHECK_EN] && !(^{i_rx_data[7:0], i_low_lane_parity}))
         |-> scsi_err_evt)
      else $error("low lane error missed");
   a_check_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
      !ctrl_zero_reg[BIT_CHECK_EN] |-> !scsi_err_evt)
      else $error("error event with checking off");
   a_check_sense: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
      scsi_err_evt |-> (!(^{i_rx_data[7:0], i_low_lane_parity}) ||
         (i_wide && !(^{i_rx_data[15:8], i_high_lane_parity}))))
      else $error("error event on good odd parity");
   a_high_narrow: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R14]
      (!i_wide && (^{i_rx_data[7:0], i_low_lane_parity})) |-> !scsi_err_evt)
      else $error("high lane checked on narrow transfer");
   a_high_wide: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R14]
      (i_rx_valid && i_wide && ctrl_zero_reg[BIT_CHECK_EN] &&
         !(^{i_rx_data[15:8], i_high_lane_parity})) |-> scsi_err_evt)
      else $error("high lane error missed");

   // sticky status until cleared
   a_err_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
      (scsi_err_reg && !(clr_wr && i_wdata[BIT_PAR_ERR])) |=> scsi_err_reg)
      else $error("parity error status lost");
   a_err_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
      (!scsi_err_evt && clr_wr && i_wdata[BIT_PAR_ERR]) |=> !scsi_err_reg)
      else $error("parity error status not cleared");

   // outgoing parity per lane
   a_tx_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3] [R14]
      (i_tx_valid && bad_par_reg == 2'h0) |=> ((^{$past(i_tx_data[15:8]), o_high_lane_parity}) == !$past(even_sel)))
      else $error("wrong high lane parity sense");
   a_bad_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
      (i_tx_valid && bad_par_reg[1]) |=> ((^{$past(i_tx_data[15:8]), o_high_lane_parity}) == $past(even_sel)))
      else $error("forced bad high parity not sent");
   a_bad_once: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
      (i_tx_valid && !(i_wr && i_addr == OFS_BAD_PARITY)) |=> (bad_par_reg == 2'h0))
      else $error("bad parity request not consumed");
   a_tx_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3]
      !i_tx_valid |=> $stable({o_high_lane_parity, o_low_lane_parity}))
      else $error("parity outputs moved without a word");

   // attention only as initiator
   a_atn_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
      (!o_attention_out_n && i_initiator) |=> !o_attention_out_n)
      else $error("attention dropped while initiator");
   a_atn_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
      !i_initiator |=> o_attention_out_n)
      else $error("attention driven as target");
   a_atn_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
      (o_attention_out_n && !(scsi_err_evt && ctrl_zero_reg[BIT_ATN_ON_ERR])) |=> o_attention_out_n)
      else $error("attention raised without cause");

   // halt immediate or deferred to transfer end
   a_halt_init: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R7]
      (scsi_err_evt && i_initiator) |=> o_halt)
      else $error("initiator did not halt");
   a_pend_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
      (scsi_err_evt && !i_initiator && ctrl_one_reg[BIT_HALT_DIS]) |=> halt_pending_reg)
      else $error("deferred halt not armed");
   a_halt_defer: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
      (scsi_err_evt && !i_initiator && ctrl_one_reg[BIT_HALT_DIS] && !o_halt && !halt_pending_reg)
         |=> !o_halt)
      else $error("target halted before transfer end");
   a_halt_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R7]
      (o_halt && !(clr_wr && i_wdata[BIT_PAR_ERR])) |=> o_halt)
      else $error("halt dropped without clear");

   // interrupt line follows enabled status
   a_irq_on: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6]
      (scsi_err_reg && irq_en_zero_reg[BIT_PAR_ERR]) |-> !o_host_irq_n)
      else $error("enabled parity irq not raised");
   a_master_irq_on: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R13]
      (master_err_reg && dma_irq_en_reg[BIT_MASTER_DPE]) |-> !o_host_irq_n)
      else $error("enabled master irq not raised");
   a_irq_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6] [R13]
      (!scsi_err_reg && !master_err_reg) |-> o_host_irq_n)
      else $error("irq with no status set");

   // master data phase status
   a_master_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R11]
      (!master_err_reg && !(i_pci_master_data && test_four_reg[BIT_MASTER_PAR_EN])) |=> !master_err_reg)
      else $error("master error set outside checked phase");
   a_master_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R12]
      (master_err_reg && !(clr_wr && i_wdata[BIT_MASTER_DPE])) |=> master_err_reg)
      else $error("master error status lost");

endmodule
`default_nettype wire

// ==== bench/scsi_peer.sv ====
// Purpose: far-side scsi party that sends words with per-lane parity
// Assumes: one send pulse per word, sampled on the rising edge
// Notes:   released bus shows the inverse of the last value, not a held copy
`timescale 1ns/1ns
`default_nettype none
module scsi_peer (
   input  wire logic        i_clk,
   input  wire logic        i_send,
   input  wire logic [15:0] i_word,
   input  wire logic [1:0]  i_bad,
   output logic      [15:0] o_rx_data,
   output logic             o_rx_valid,
   output logic             o_low_par,
   output logic             o_high_par
);
   initial begin
      o_rx_data  = 16'h0000;
      o_rx_valid = 1'b0;
      o_low_par  = 1'b0;
      o_high_par = 1'b0;
   end
   // odd parity per lane, inverted on command, bus released after one cycle
   always @(posedge i_clk) begin
      if (i_send) begin
         o_rx_data  <= i_word;
         o_low_par  <= ~^i_word[7:0] ^ i_bad[0];
         o_high_par <= ~^i_word[15:8] ^ i_bad[1];
      end else if (o_rx_valid) begin
         o_rx_data  <= ~o_rx_data;
         o_low_par  <= ~o_low_par;
         o_high_par <= ~o_high_par;
      end
      o_rx_valid <= i_send;
   end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: register-level tests of the scsi parity control block
// Assumes: reads answer one cycle after the strobe
// Notes:   expected parity is worked out here from the data
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module testbench;
   import scsi_parity_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, txv = 0, init = 0, wide = 0, xend = 0, pmd = 1, tperr = 0, send = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [15:0] txd = 16'h0, word = 16'h0, rxd;
   logic [1:0]  bad = 2'h0;
   logic        rxv, lp, hp, olp, ohp, atn_n, halt, irq_n;
   int          n_errors = 0, comparisons = 0;
   always #2 clk = ~clk;
   scsi_peer i_scsi_peer (.i_clk(clk), .i_send(send), .i_word(word), .i_bad(bad), .o_rx_data(rxd),
      .o_rx_valid(rxv), .o_low_par(lp), .o_high_par(hp));
   scsi_parity_control i_scsi_parity_control (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_initiator(init), .i_wide(wide), .i_tx_data(txd),
      .i_tx_valid(txv), .o_low_lane_parity(olp), .o_high_lane_parity(ohp), .i_rx_data(rxd),
      .i_rx_valid(rxv), .i_low_lane_parity(lp), .i_high_lane_parity(hp), .i_xfer_end(xend),
      .i_pci_master_data(pmd), .i_pci_target_perr(tperr), .o_attention_out_n(atn_n), .o_halt(halt),
      .o_host_irq_n(irq_n));
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   // send a word and check both lane parity outputs, e = even sense, b = forced bad lanes
   task automatic tx(input logic [15:0] d, input logic e, input logic [1:0] b);
      @(posedge clk) begin txd <= d; txv <= 1'b1; end
      @(posedge clk) txv <= 1'b0;
      #1 `CHK({ohp, olp}, {~^d[15:8] ^ e ^ b[1], ~^d[7:0] ^ e ^ b[0]})
   endtask
   task automatic snd(input logic [15:0] d, input logic [1:0] b);
      @(posedge clk) begin word <= d; bad <= b; send <= 1'b1; end
      @(posedge clk) send <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic pulse_perr();
      @(posedge clk) tperr <= 1'b1;
      @(posedge clk) tperr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1 `CHK({atn_n, halt, irq_n, olp, ohp}, 5'b10111)
      r(OFS_IRQ_STAT_ZERO, 32'h0);
      r(8'hFC, 32'h0);
      tx(16'h0301, 1'b0, 2'h0);
      w(OFS_CTRL_ONE, 32'h04);
      tx(16'h0700, 1'b1, 2'h0);
      w(OFS_BAD_PARITY, 32'h03);
      tx(16'h0F0F, 1'b1, 2'h3);
      tx(16'h0F0F, 1'b1, 2'h0);
      // checking off: bad word is not flagged, live and latched parity readable
      snd(16'h0101, 2'h1);
      r(OFS_IRQ_STAT_ZERO, 32'h0);
      r(OFS_STATUS_ZERO, 32'h00);
      snd(16'h0101, 2'h0);
      r(OFS_STATUS_ZERO, 32'h01);
      r(OFS_STATUS_TWO, 32'h01);
      snd(16'h0000, 2'h0);
      r(OFS_STATUS_ONE, 32'h08);
      r(OFS_STATUS_TWO, 32'h08);
      // checking on with even transmit sense: odd is still expected
      w(OFS_CTRL_ZERO, 32'h08);
      snd(16'h0101, 2'h2);
      r(OFS_IRQ_STAT_ZERO, 32'h0);
      @(posedge clk) wide <= 1'b1;
      snd(16'h0101, 2'h2);
      `CHK({halt, irq_n, atn_n}, 3'b111)
      r(OFS_IRQ_STAT_ZERO, 32'h1);
      w(OFS_IRQ_CLEAR, 32'h01);
      r(OFS_IRQ_STAT_ZERO, 32'h0);
      w(OFS_IRQ_EN_ZERO, 32'h01);
      w(OFS_CTRL_ZERO, 32'h0A);
      @(posedge clk) init <= 1'b1;
      snd(16'h0101, 2'h1);
      `CHK({halt, irq_n, atn_n}, 3'b100)
      w(OFS_IRQ_CLEAR, 32'h01);
      @(posedge clk) init <= 1'b0;
      // target mode with halt disabled waits for the end of transfer
      w(OFS_CTRL_ONE, 32'h24);
      snd(16'h0101, 2'h1);
      `CHK({halt, irq_n}, 2'b00)
      @(posedge clk) xend <= 1'b1;
      @(posedge clk) xend <= 1'b0;
      #1 `CHK(halt, 1'b1)
      w(OFS_IRQ_CLEAR, 32'h01);
      pulse_perr();
      r(OFS_DMA_STATUS, 32'h00);
      w(OFS_TEST_FOUR, 32'h08);
      pulse_perr();
      r(OFS_DMA_STATUS, 32'h40);
      `CHK(irq_n, 1'b1)
      w(OFS_DMA_IRQ_EN, 32'h40);
      #1 `CHK(irq_n, 1'b0)
      // outside a master data phase a target error is not recorded
      w(OFS_IRQ_CLEAR, 32'h40);
      r(OFS_DMA_STATUS, 32'h00);
      @(posedge clk) pmd <= 1'b0;
      pulse_perr();
      r(OFS_DMA_STATUS, 32'h00);
      `CHK(irq_n, 1'b1)
      stop_test();
   end
endmodule
`undef CHK
`default_nettype wire
